/* File: cache_regs_pkg.sv */
// constants for the cache remap and monitor register block
package cache_regs_pkg;

	// register byte addresses, application cache controller
	localparam logic [31:0] EMBEDDED_WINDOW_SETUP_ADDR     = 32'h1A0C0044;
	localparam logic [31:0] ONE_WAIT_HIT_TALLY_ADDR        = 32'h1A0C0048;
	localparam logic [31:0] DEBUGGER_RESET_REQUEST_ADDR    = 32'h1A0C0050;
	localparam logic [31:0] EVENT_STATUS_ADDR              = 32'h1A0C0060;
	localparam logic [31:0] EVENT_CLEAR_ADDR               = 32'h1A0C0064;
	localparam logic [31:0] EVENT_ENABLE_ADDR              = 32'h1A0C0068;

	// register byte addresses, protocol engine cache controller
	localparam logic [31:0] ENGINE_CACHE_CONTROL_TWO_ADDR  = 32'h1A1C0020;
	localparam logic [31:0] ENGINE_MONITOR_HIT_COUNT_ADDR  = 32'h1A1C0028;
	localparam logic [31:0] ENGINE_MONITOR_MISS_COUNT_ADDR = 32'h1A1C002C;
	localparam logic [31:0] ENGINE_MONITOR_CONTROL_ADDR    = 32'h1A1C0030;
	localparam logic [31:0] ENGINE_MONITOR_INTERVAL_ADDR   = 32'h1A1C0034;
	localparam logic [31:0] ENGINE_MONITOR_MISS_LIMIT_ADDR = 32'h1A1C0038;
	localparam logic [31:0] ENGINE_MONITOR_HIT_LIMIT_ADDR  = 32'h1A1C003C;
	localparam logic [31:0] ENGINE_EXTERNAL_WINDOW_ADDR    = 32'h1A1C0040;
	localparam logic [31:0] ENGINE_EMBEDDED_WINDOW_ADDR    = 32'h1A1C0044;
	localparam logic [31:0] ENGINE_ONE_WAIT_HIT_TALLY_ADDR = 32'h1A1C0048;
	localparam logic [31:0] ENGINE_DEBUGGER_RESET_ADDR     = 32'h1A1C0050;

	// window setup field layout and reset values
	localparam int          WINDOW_BASE_LSB       = 16;
	localparam int          WINDOW_OFFSET_LSB     = 4;
	localparam int          WINDOW_SIZE_LSB       = 0;
	localparam logic [7:0]  WINDOW_BASE_RESET     = 8'hA0;
	localparam logic [7:0]  WINDOW_BASE_TOP_BYTE  = 8'h00;
	localparam logic [11:0] WINDOW_OFFSET_RESET   = 12'h000;
	localparam logic [2:0]  WINDOW_SIZE_RESET     = 3'h6;

	// window size encodings
	localparam logic [2:0]  WINDOW_SIZE_512K      = 3'h4;
	localparam logic [2:0]  WINDOW_SIZE_256K      = 3'h5;
	localparam logic [2:0]  WINDOW_SIZE_128K      = 3'h6;
	localparam logic [2:0]  WINDOW_SIZE_64K       = 3'h7;
	localparam logic [31:0] WINDOW_MASK_512K      = 32'h0007FFFF;
	localparam logic [31:0] WINDOW_MASK_256K      = 32'h0003FFFF;
	localparam logic [31:0] WINDOW_MASK_128K      = 32'h0001FFFF;
	localparam logic [31:0] WINDOW_MASK_64K       = 32'h0000FFFF;

	// engine control two field layout
	localparam int          CACHE_READY_BIT       = 28;
	localparam int          CACHE_RAM_INIT_BIT    = 27;
	localparam int          SPAN_LENGTH_LSB       = 17;
	localparam logic [8:0]  SPAN_LENGTH_RESET     = 9'h000;
	localparam int          SPAN_BLOCK_LSB        = 16;

	// flush duration
	localparam int          FLUSH_CYCLES          = 256;

	// event bits
	localparam int          EVENT_COUNT           = 3;
	localparam int          EVT_ENGINE_READY      = 0;
	localparam int          EVT_TALLY_WRAP        = 1;
	localparam int          EVT_DEBUG_REFUSED     = 2;

	// engine cache controller states
	typedef enum logic [1:0] {
		ENGINE_OFF,
		ENGINE_FLUSH,
		ENGINE_READY
	} engine_state_e;

endpackage : cache_regs_pkg

/* File: cache_remap_and_monitor_regs.sv */
// register block for both instruction cache controllers, remap logic for the application one
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - top byte of the window base is always zero, whatever is written
// - window base field reads 0xA0 after reset
// - word offset is added to fetch address bits 13 down to 2
// - new base, offset or size take effect only at software reset
// - window fields survive power-saving states with retention
// - size codes: 4=512k, 5=256k, 6=128k, 7=64k, 0..3=512k; reset 6
// - 32-bit writable hit counter, reset to zero
// - writing one to bit 0 requests hardware reset; reads zero, cleared by it
// - debugger reset bit accepts debug path accesses only
// - engine cache does no remapping; its window registers do nothing
// - ready bit 28 set when enabled, initialised and able to serve
// - init bit 27 high during flush; flush lasts 256 bus cycles
// - bits 25:17 hold cacheable length, reset zero
// - length selects N blocks of 64 kB; zero disables caching
module cache_remap_and_monitor_regs #(
	parameter int unsigned FLUSH_LEN = cache_regs_pkg::FLUSH_CYCLES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// register port
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	input  wire logic        debug_access_i,
	output logic      [31:0] rd_data_o,
	// system events
	input  wire logic        software_reset_i,
	input  wire logic        hardware_reset_event_i,
	input  wire logic        retention_wake_i,
	output logic             debugger_reset_request_o,
	// application cache fetch path
	input  wire logic        fetch_valid_i,
	input  wire logic [31:0] fetch_addr_i,
	input  wire logic        one_wait_hit_i,
	output logic             remap_valid_o,
	output logic      [31:0] remap_addr_o,
	// protocol engine cache
	input  wire logic        engine_enable_i,
	input  wire logic        engine_fetch_valid_i,
	input  wire logic [31:0] engine_fetch_addr_i,
	input  wire logic        engine_one_wait_hit_i,
	output logic             engine_cacheable_o,
	// interrupt
	output logic             irq_o
);
	import cache_regs_pkg::*;

	localparam int CNT_W = $clog2(FLUSH_LEN + 1);

	// retained window setup: programmed and active copies
	logic [7:0]             base_prog_reg;
	logic [11:0]            offset_prog_reg;
	logic [2:0]             size_prog_reg;
	logic [7:0]             base_act_reg;
	logic [11:0]            offset_act_reg;
	logic [2:0]             size_act_reg;

	// counters and monitor storage
	logic [31:0]            hit_tally_reg;
	logic [31:0]            hit_tally_next;
	logic [31:0]            engine_tally_reg;
	logic [31:0]            engine_tally_next;
	logic [31:0]            monitor_reg [6];

	// engine controller state
	engine_state_e          engine_state_reg;
	engine_state_e          engine_state_next;
	logic [CNT_W-1:0]       flush_cnt_reg;
	logic [8:0]             span_length_reg;

	// debugger request, events, read path
	logic                   dbg_req_reg;
	logic [EVENT_COUNT-1:0] status_reg;
	logic [EVENT_COUNT-1:0] status_next;
	logic [EVENT_COUNT-1:0] enable_reg;
	logic [EVENT_COUNT-1:0] event_set;
	logic [31:0]            rd_data_next;

	// address decode
	wire sel_window   = (addr_i == EMBEDDED_WINDOW_SETUP_ADDR);
	wire sel_tally    = (addr_i == ONE_WAIT_HIT_TALLY_ADDR);
	wire sel_dbg      = (addr_i == DEBUGGER_RESET_REQUEST_ADDR);
	wire sel_status   = (addr_i == EVENT_STATUS_ADDR);
	wire sel_clear    = (addr_i == EVENT_CLEAR_ADDR);
	wire sel_enable   = (addr_i == EVENT_ENABLE_ADDR);
	wire sel_ctrl_two = (addr_i == ENGINE_CACHE_CONTROL_TWO_ADDR);
	wire sel_e_tally  = (addr_i == ENGINE_ONE_WAIT_HIT_TALLY_ADDR);
	wire sel_e_dbg    = (addr_i == ENGINE_DEBUGGER_RESET_ADDR);
	wire [5:0] sel_mon = {
		addr_i == ENGINE_MONITOR_HIT_LIMIT_ADDR,
		addr_i == ENGINE_MONITOR_MISS_LIMIT_ADDR,
		addr_i == ENGINE_MONITOR_INTERVAL_ADDR,
		addr_i == ENGINE_MONITOR_CONTROL_ADDR,
		addr_i == ENGINE_MONITOR_MISS_COUNT_ADDR,
		addr_i == ENGINE_MONITOR_HIT_COUNT_ADDR
	};

	// write strobes per register
	wire wr_window   = wr_en_i & sel_window;
	wire wr_tally    = wr_en_i & sel_tally;
	wire wr_clear    = wr_en_i & sel_clear;
	wire wr_enable   = wr_en_i & sel_enable;
	wire wr_ctrl_two = wr_en_i & sel_ctrl_two;
	wire wr_e_tally  = wr_en_i & sel_e_tally;
	wire dbg_touch   = (wr_en_i | rd_en_i) & (sel_dbg | sel_e_dbg);
	wire dbg_set     = wr_en_i & (sel_dbg | sel_e_dbg) & debug_access_i & wr_data_i[0];
	wire dbg_refused = dbg_touch & ~debug_access_i;

	// window mask from the size code
	function automatic logic [31:0] window_mask(input logic [2:0] code);
		logic [31:0] m;
		m = WINDOW_MASK_512K;
		unique case (code)
			WINDOW_SIZE_256K: m = WINDOW_MASK_256K;
			WINDOW_SIZE_128K: m = WINDOW_MASK_128K;
			WINDOW_SIZE_64K:  m = WINDOW_MASK_64K;
			default:          m = WINDOW_MASK_512K; // codes 0..4
		endcase
		return m;
	endfunction : window_mask

	// remapped address from the active setup only
	wire [31:0] window_base = {WINDOW_BASE_TOP_BYTE, base_act_reg, 16'h0000};
	wire [31:0] window_part = fetch_addr_i & window_mask(size_act_reg);
	wire [11:0] word_sum    = fetch_addr_i[13:2] + offset_act_reg;
	wire [31:0] remap_next  = window_base | {window_part[31:14], word_sum, window_part[1:0]};

	// engine cacheable check: N blocks of 64 kB, zero disables
	wire [15:0] engine_block = engine_fetch_addr_i[31:SPAN_BLOCK_LSB];
	wire        engine_in_span = (span_length_reg != SPAN_LENGTH_RESET)
		& (engine_block < {7'h00, span_length_reg});
	wire        engine_ready = (engine_state_reg == ENGINE_READY);
	wire        engine_flush = (engine_state_reg == ENGINE_FLUSH);

	// counter next values, software write wins over a hit
	assign hit_tally_next    = wr_tally ? wr_data_i : hit_tally_reg + 32'h00000001;
	assign engine_tally_next = wr_e_tally ? wr_data_i : engine_tally_reg + 32'h00000001;

	// engine controller sequencing
	always_comb begin
		engine_state_next = engine_state_reg;
		unique case (engine_state_reg)
			ENGINE_OFF: begin
				if (engine_enable_i) begin
					engine_state_next = ENGINE_FLUSH;
				end
			end
			ENGINE_FLUSH: begin
				if (!engine_enable_i) begin
					engine_state_next = ENGINE_OFF;
				end else if (flush_cnt_reg == CNT_W'(FLUSH_LEN - 1)) begin
					engine_state_next = ENGINE_READY;
				end
			end
			ENGINE_READY: begin
				if (!engine_enable_i) begin
					engine_state_next = ENGINE_OFF;
				end
			end
		endcase
	end

	// event sources and sticky status, set wins over clear
	assign event_set[EVT_ENGINE_READY]  = engine_flush & (engine_state_next == ENGINE_READY);
	assign event_set[EVT_TALLY_WRAP]    = one_wait_hit_i & ~wr_tally & (&hit_tally_reg);
	assign event_set[EVT_DEBUG_REFUSED] = dbg_refused;
	assign status_next = (status_reg & ~(wr_clear ? wr_data_i[EVENT_COUNT-1:0]
		: {EVENT_COUNT{1'b0}})) | event_set;

	// read mux; reserved and unmapped bits read zero
	always_comb begin
		rd_data_next = 32'h00000000;
		if (sel_window) begin
			rd_data_next = {WINDOW_BASE_TOP_BYTE, base_prog_reg, offset_prog_reg,
				1'b0, size_prog_reg};
		end else if (sel_tally) begin
			rd_data_next = hit_tally_reg;
		end else if (sel_status) begin
			rd_data_next[EVENT_COUNT-1:0] = status_reg;
		end else if (sel_enable) begin
			rd_data_next[EVENT_COUNT-1:0] = enable_reg;
		end else if (sel_ctrl_two) begin
			rd_data_next[CACHE_READY_BIT]    = engine_ready;
			rd_data_next[CACHE_RAM_INIT_BIT] = engine_flush;
			rd_data_next[SPAN_LENGTH_LSB +: 9] = span_length_reg;
		end else if (sel_e_tally) begin
			rd_data_next = engine_tally_reg;
		end
		for (int i = 0; i < 6; i++) begin
			if (sel_mon[i]) begin
				rd_data_next = monitor_reg[i];
			end
		end
		if (!rd_en_i) begin
			rd_data_next = 32'h00000000;
		end
	end

	// retained window setup: only the power-on reset clears it
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			base_prog_reg   <= WINDOW_BASE_RESET;
			offset_prog_reg <= WINDOW_OFFSET_RESET;
			size_prog_reg   <= WINDOW_SIZE_RESET;
		end else if (wr_window) begin
			base_prog_reg   <= wr_data_i[WINDOW_BASE_LSB +: 8];
			offset_prog_reg <= wr_data_i[WINDOW_OFFSET_LSB +: 12];
			size_prog_reg   <= wr_data_i[WINDOW_SIZE_LSB +: 3];
		end
	end

	// active setup follows programmed one at software reset
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			base_act_reg   <= WINDOW_BASE_RESET;
			offset_act_reg <= WINDOW_OFFSET_RESET;
			size_act_reg   <= WINDOW_SIZE_RESET;
		end else if (software_reset_i) begin
			base_act_reg   <= base_prog_reg;
			offset_act_reg <= offset_prog_reg;
			size_act_reg   <= size_prog_reg;
		end
	end

	// remapped fetch address
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			remap_valid_o <= 1'b0;
			remap_addr_o  <= 32'h00000000;
		end else begin
			remap_valid_o <= fetch_valid_i;
			remap_addr_o  <= remap_next;
		end
	end

	// one wait state hit tallies; lost on wake without retention
	always_ff @(posedge mclk_i) begin
		if (!resetn_i || retention_wake_i) begin
			hit_tally_reg    <= 32'h00000000;
			engine_tally_reg <= 32'h00000000;
		end else begin
			if (wr_tally || one_wait_hit_i) begin
				hit_tally_reg <= hit_tally_next;
			end
			if (wr_e_tally || engine_one_wait_hit_i) begin
				engine_tally_reg <= engine_tally_next;
			end
		end
	end

	// engine monitor storage words
	generate
		for (genvar g = 0; g < 6; g++) begin : gen_monitor
			always_ff @(posedge mclk_i) begin
				if (!resetn_i) begin
					monitor_reg[g] <= 32'h00000000;
				end else if (wr_en_i && sel_mon[g]) begin
					monitor_reg[g] <= wr_data_i;
				end
			end
		end
	endgenerate

	// engine control two and flush sequencing
	always_ff @(posedge mclk_i) begin
		if (!resetn_i || retention_wake_i) begin
			engine_state_reg <= ENGINE_OFF;
			flush_cnt_reg    <= '0;
			span_length_reg  <= SPAN_LENGTH_RESET;
		end else begin
			engine_state_reg <= engine_state_next;
			if (engine_flush) begin
				flush_cnt_reg <= flush_cnt_reg + CNT_W'(1);
			end else begin
				flush_cnt_reg <= '0;
			end
			if (wr_ctrl_two) begin
				span_length_reg <= wr_data_i[SPAN_LENGTH_LSB +: 9];
			end
		end
	end

	// engine cacheability, no remapping in this path
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			engine_cacheable_o <= 1'b0;
		end else begin
			engine_cacheable_o <= engine_fetch_valid_i & engine_ready & engine_in_span;
		end
	end

	// debugger reset request, set wins over the reset event
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			dbg_req_reg <= 1'b0;
		end else if (dbg_set) begin
			dbg_req_reg <= 1'b1;
		end else if (hardware_reset_event_i) begin
			dbg_req_reg <= 1'b0;
		end
	end
	assign debugger_reset_request_o = dbg_req_reg;

	// event status, enable and interrupt line
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			status_reg <= '0;
			enable_reg <= '0;
			irq_o      <= 1'b0;
		end else begin
			status_reg <= status_next;
			if (wr_enable) begin
				enable_reg <= wr_data_i[EVENT_COUNT-1:0];
			end
			irq_o <= |(status_next & (wr_enable ? wr_data_i[EVENT_COUNT-1:0] : enable_reg));
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rd_data_o <= 32'h00000000;
		end else begin
			rd_data_o <= rd_data_next;
		end
	end

endmodule : cache_remap_and_monitor_regs

/* File: cache_remap_and_monitor_regs_chk.sv */
// assertion checker for the cache register block
`timescale 1ns/1ps
module cache_remap_and_monitor_regs_chk import cache_regs_pkg::*; #(
	parameter int unsigned FLUSH_LEN = 256
) (
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	// register port
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic        wr_en_i,
	input wire logic        rd_en_i,
	input wire logic        debug_access_i,
	input wire logic [31:0] rd_data_o,
	// events
	input wire logic        hardware_reset_event_i,
	input wire logic        retention_wake_i,
	input wire logic        debugger_reset_request_o,
	// fetch paths
	input wire logic        fetch_valid_i,
	input wire logic [31:0] fetch_addr_i,
	input wire logic        remap_valid_o,
	input wire logic [31:0] remap_addr_o,
	input wire logic        engine_enable_i,
	input wire logic        engine_fetch_valid_i,
	input wire logic [31:0] engine_fetch_addr_i,
	input wire logic        engine_cacheable_o
);
	logic [15:0] en_cnt;
	logic [8:0]  span_q;
	wire         dbg_wr = wr_en_i && (addr_i == DEBUGGER_RESET_REQUEST_ADDR
		|| addr_i == ENGINE_DEBUGGER_RESET_ADDR);

	// run length of enable and shadow of the programmed span
	always_ff @(posedge mclk_i) begin
		if (!resetn_i || retention_wake_i || !engine_enable_i) en_cnt <= '0;
		else if (en_cnt != 16'hFFFF) en_cnt <= en_cnt + 16'h1;
		if (!resetn_i || retention_wake_i) span_q <= '0;
		else if (wr_en_i && addr_i == ENGINE_CACHE_CONTROL_TWO_ADDR) span_q <= wr_data_i[25:17];
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	property p_dbg_set; dbg_wr && debug_access_i && wr_data_i[0] |=> debugger_reset_request_o; endproperty
	a_dbg_set: assert property (p_dbg_set) else $error("request not raised");
	property p_dbg_refuse;
		dbg_wr && !debug_access_i && !debugger_reset_request_o |=> !debugger_reset_request_o;
	endproperty
	a_dbg_refuse: assert property (p_dbg_refuse) else $error("app write raised request");
	property p_dbg_clear;
		hardware_reset_event_i && !(dbg_wr && debug_access_i) |=> !debugger_reset_request_o;
	endproperty
	a_dbg_clear: assert property (p_dbg_clear) else $error("request not cleared");
	property p_dbg_read; rd_en_i && addr_i == DEBUGGER_RESET_REQUEST_ADDR |=> rd_data_o == 32'h0; endproperty
	a_dbg_read: assert property (p_dbg_read) else $error("request reads nonzero");
	property p_eng_win;
		rd_en_i && (addr_i == ENGINE_EXTERNAL_WINDOW_ADDR || addr_i == ENGINE_EMBEDDED_WINDOW_ADDR)
			|=> rd_data_o == 32'h0;
	endproperty
	a_eng_win: assert property (p_eng_win) else $error("engine window reads nonzero");
	property p_remap_lsb;
		fetch_valid_i |=> remap_valid_o && remap_addr_o[1:0] == $past(fetch_addr_i[1:0]);
	endproperty
	a_remap_lsb: assert property (p_remap_lsb) else $error("remap late or byte bits moved");
	property p_span;
		engine_cacheable_o |-> $past(engine_fetch_valid_i)
			&& $past(engine_fetch_addr_i[31:16]) < {7'h00, $past(span_q)};
	endproperty
	a_span: assert property (p_span) else $error("cacheable outside span");
	property p_wait;
		engine_cacheable_o && $past(engine_enable_i) && !$past(retention_wake_i) |-> en_cnt > FLUSH_LEN;
	endproperty
	a_wait: assert property (p_wait) else $error("cacheable before flush end");
	property p_ready;
		en_cnt > FLUSH_LEN + 2 && engine_enable_i && !retention_wake_i && engine_fetch_valid_i
			&& engine_fetch_addr_i[31:16] < {7'h00, span_q} |=> engine_cacheable_o;
	endproperty
	a_ready: assert property (p_ready) else $error("ready cache not serving");
endmodule : cache_remap_and_monitor_regs_chk

bind cache_remap_and_monitor_regs cache_remap_and_monitor_regs_chk #(.FLUSH_LEN(FLUSH_LEN)) u_chk (.*);

/* File: fetch_core_model.sv */
// processor core model issuing fetches and hit pulses
`timescale 1ns/1ps
module fetch_core_model (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// hit pulse gate
	input  wire logic        hit_en_i,
	// fetch side
	output logic             fetch_valid_o,
	output logic      [31:0] fetch_addr_o,
	output logic             one_wait_hit_o,
	output logic             engine_fetch_valid_o,
	output logic      [31:0] engine_fetch_addr_o,
	output logic      [31:0] hit_count_o
);
	int          seed = 32'h9FAE02E2;
	logic [31:0] r;

	// quiet outputs at time zero
	initial {fetch_valid_o, fetch_addr_o, one_wait_hit_o} = '0;
	initial {engine_fetch_valid_o, engine_fetch_addr_o, hit_count_o} = '0;

	// random fetches; address churns while idle so stale values never match
	always @(posedge mclk_i) begin
		r = $random(seed);
		fetch_valid_o <= resetn_i & r[0];
		fetch_addr_o <= $random(seed);
		one_wait_hit_o <= resetn_i & hit_en_i & r[1];
		engine_fetch_valid_o <= resetn_i & r[2];
		engine_fetch_addr_o <= {13'h0000, r[5:3], r[31:16]};
		hit_count_o <= !resetn_i ? 32'h0 : hit_count_o + {31'h0, one_wait_hit_o};
	end
endmodule : fetch_core_model

/* File: tb_cache_remap_and_monitor_regs.sv */
// self-checking bench for the cache register block
`timescale 1ns/1ps
module tb_cache_remap_and_monitor_regs;
	import cache_regs_pkg::*;
	localparam int unsigned FL = 8;
	logic mclk_i = 1'b0, resetn_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, debug_access_i = 1'b0;
	logic software_reset_i = 1'b0, hardware_reset_event_i = 1'b0, retention_wake_i = 1'b0;
	logic engine_enable_i = 1'b0, engine_one_wait_hit_i = 1'b0, hit_en = 1'b0, rd_seen = 1'b0;
	logic [31:0] addr_i = '0, wr_data_i = '0, prog, act = 32'h00A00006;
	logic [31:0] rd_data_o, remap_addr_o, fetch_addr_i, engine_fetch_addr_i, hits;
	logic debugger_reset_request_o, fetch_valid_i, one_wait_hit_i, remap_valid_o, irq_o;
	logic engine_fetch_valid_i, engine_cacheable_o;
	logic [31:0] rq[$], mq[$];
	logic [31:0] rw[8] = '{ENGINE_MONITOR_HIT_COUNT_ADDR, ENGINE_MONITOR_MISS_COUNT_ADDR,
		ENGINE_MONITOR_CONTROL_ADDR, ENGINE_MONITOR_INTERVAL_ADDR, ENGINE_MONITOR_MISS_LIMIT_ADDR,
		ENGINE_MONITOR_HIT_LIMIT_ADDR, ENGINE_ONE_WAIT_HIT_TALLY_ADDR, ONE_WAIT_HIT_TALLY_ADDR};
	int fail_count = 0, compares = 0, seed = 32'h9FAE02E2;

	cache_remap_and_monitor_regs #(.FLUSH_LEN(FL)) DUT (.*);
	fetch_core_model u_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .hit_en_i(hit_en),
		.fetch_valid_o(fetch_valid_i), .fetch_addr_o(fetch_addr_i), .one_wait_hit_o(one_wait_hit_i),
		.engine_fetch_valid_o(engine_fetch_valid_i), .engine_fetch_addr_o(engine_fetch_addr_i),
		.hit_count_o(hits));

	// 100 MHz clock
	always #5 mclk_i = ~mclk_i;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chkb(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask : chkb
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic g = 1'b0);
		@(posedge mclk_i);
		addr_i <= a;
		wr_data_i <= d;
		debug_access_i <= g;
		wr_en_i <= 1'b1;
		@(posedge mclk_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic g = 1'b0);
		rq.push_back(e);
		@(posedge mclk_i);
		addr_i <= a;
		debug_access_i <= g;
		rd_en_i <= 1'b1;
		@(posedge mclk_i);
		rd_en_i <= 1'b0;
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask : settle
	task automatic complete_run;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	function automatic logic [31:0] remap(input logic [31:0] a);
		logic [31:0] m;
		m = a & (act[2:0] == 3'h5 ? WINDOW_MASK_256K : act[2:0] == 3'h6 ? WINDOW_MASK_128K :
			act[2:0] == 3'h7 ? WINDOW_MASK_64K : WINDOW_MASK_512K);
		return {8'h00, act[23:16], 16'h0000} | {m[31:14], m[13:2] + act[15:4], m[1:0]};
	endfunction : remap

	// scoreboard: oldest note against each read answer and remap result
	always @(posedge mclk_i) begin
		if (rd_seen) chk("rd_data_o", rq.pop_front(), rd_data_o);
		rd_seen <= rd_en_i;
		if (remap_valid_o) chk("remap_addr_o", mq.pop_front(), remap_addr_o);
		if (fetch_valid_i && resetn_i) mq.push_back(remap(fetch_addr_i));
		if (software_reset_i) act = prog;
	end

	// watchdog
	initial begin
		repeat (5000) @(posedge mclk_i);
		fail_count++;
		complete_run();
	end

	// main sequence
	initial begin
		logic [31:0] v;
		repeat (2) @(posedge mclk_i);
		resetn_i <= 1'b1;
		rd(EMBEDDED_WINDOW_SETUP_ADDR, 32'h00A00006);
		rd(ONE_WAIT_HIT_TALLY_ADDR, 32'h0);
		rd(ENGINE_CACHE_CONTROL_TWO_ADDR, 32'h0);
		$display("test reset done");
		wr(DEBUGGER_RESET_REQUEST_ADDR, 32'h1);
		settle;
		chkb("debugger_reset_request_o", 1'b0, debugger_reset_request_o);
		rd(EVENT_STATUS_ADDR, 32'h4);
		chkb("irq_o", 1'b0, irq_o);
		wr(EVENT_ENABLE_ADDR, 32'h4);
		settle;
		chkb("irq_o", 1'b1, irq_o);
		wr(EVENT_CLEAR_ADDR, 32'h4);
		settle;
		chkb("irq_o", 1'b0, irq_o);
		rd(EVENT_STATUS_ADDR, 32'h0);
		wr(DEBUGGER_RESET_REQUEST_ADDR, 32'h1, 1'b1);
		settle;
		chkb("debugger_reset_request_o", 1'b1, debugger_reset_request_o);
		rd(DEBUGGER_RESET_REQUEST_ADDR, 32'h0, 1'b1);
		@(posedge mclk_i) hardware_reset_event_i <= 1'b1;
		@(posedge mclk_i) hardware_reset_event_i <= 1'b0;
		settle;
		chkb("debugger_reset_request_o", 1'b0, debugger_reset_request_o);
		$display("test debugger and interrupt done");
		wr(ENGINE_CACHE_CONTROL_TWO_ADDR, 32'hFFFFFFFF);
		rd(ENGINE_CACHE_CONTROL_TWO_ADDR, 32'h03FE0000);
		wr(ENGINE_CACHE_CONTROL_TWO_ADDR, 32'h00060000);
		@(posedge mclk_i) engine_enable_i <= 1'b1;
		rd(ENGINE_CACHE_CONTROL_TWO_ADDR, 32'h08060000);
		repeat (FL + 4) @(posedge mclk_i);
		rd(ENGINE_CACHE_CONTROL_TWO_ADDR, 32'h10060000);
		rd(EVENT_STATUS_ADDR, 32'h1);
		wr(ENGINE_EXTERNAL_WINDOW_ADDR, 32'hFFFFFFFF);
		wr(ENGINE_EMBEDDED_WINDOW_ADDR, 32'hFFFFFFFF);
		rd(ENGINE_EXTERNAL_WINDOW_ADDR, 32'h0);
		rd(ENGINE_EMBEDDED_WINDOW_ADDR, 32'h0);
		wr(32'h1A1C0000, 32'hFFFFFFFF);
		rd(32'h1A1C0000, 32'h0);
		$display("test engine done");
		foreach (rw[i]) begin
			v = $random(seed);
			wr(rw[i], v);
			rd(rw[i], v);
		end
		$display("test plain words done");
		for (int s = 0; s < 8; s++) begin
			v = $random(seed);
			prog = {8'h00, v[23:4], 1'b0, s[2:0]};
			wr(EMBEDDED_WINDOW_SETUP_ADDR, {v[31:3], s[2:0]} | 32'hFF000008);
			rd(EMBEDDED_WINDOW_SETUP_ADDR, prog);
			repeat (6) @(posedge mclk_i);
			@(posedge mclk_i) software_reset_i <= 1'b1;
			@(posedge mclk_i) software_reset_i <= 1'b0;
			repeat (6) @(posedge mclk_i);
		end
		@(posedge mclk_i) retention_wake_i <= 1'b1;
		@(posedge mclk_i) retention_wake_i <= 1'b0;
		rd(EMBEDDED_WINDOW_SETUP_ADDR, prog);
		$display("test window remap done");
		wr(ONE_WAIT_HIT_TALLY_ADDR, 32'hFFFFFFFF);
		@(posedge mclk_i) hit_en <= 1'b1;
		repeat (40) @(posedge mclk_i);
		hit_en <= 1'b0;
		settle;
		rd(ONE_WAIT_HIT_TALLY_ADDR, hits - 32'h1);
		rd(EVENT_STATUS_ADDR, {29'h0, 1'b0, hits != 32'h0, 1'b1});
		settle;
		chkb("remap backlog", 1'b0, mq.size() > 1);
		$display("test hit tally done");
		complete_run();
	end
endmodule : tb_cache_remap_and_monitor_regs
